//--- design/sio2_ctrl.sv
// sio2_ctrl: transfer start/stop, wait release and clock pin control of serial interface 2
// assumes: software bits arrive as ports on the same clock; link pins are asynchronous
`timescale 1ns/1ps
module sio2_ctrl (
  input wire logic clock,
  input wire logic resetn,
  input wire logic ce_resetn,
  input wire logic [1:0] mode,
  input wire logic iface_enable_flag,
  input wire logic busy_enable_flag,
  input wire logic wake_up_flag,
  input wire logic clock_level_control,
  input wire logic wait_release_flag,
  input wire logic release_trigger_flag,
  input wire logic clock_port_bit,
  input wire logic three_wire_clock_port_bit,
  input wire logic data_port_bit,
  input wire logic clock_pin_dir_bit,
  input wire logic data_pin_dir_bit,
  input wire logic [6:0] slave_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic clk_pin_i,
  input wire logic data_pin_i,
  output logic clk_pin_o,
  output logic clk_pin_oe,
  output logic data_pin_o,
  output logic data_pin_oe,
  output logic transfer_done_irq_flag,
  output logic clock_level_detect,
  output logic address_match_flag,
  output logic command_detect_flag,
  output logic in_wait,
  output logic [7:0] preset_shift_reg,
  output logic [7:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready
);
  import sio2_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic [1:0] clk_s;      // clock pin synchroniser
    logic [1:0] dat_s;      // data pin synchroniser
    logic clk_prev;         // last synced clock level
    logic dat_prev;         // last synced data level
    sio2_state_e st;        // engine state
    logic [3:0] cnt;        // bits shifted
    logic [7:0] sh;         // shift register
    logic pend;             // set by a write in wait, cleared in that same cycle
    logic armed;            // cleared when enable rises, never set
    logic en_prev;          // enable seen last cycle
    logic irq;              // transfer done flag
    logic coi;              // address match flag
    logic cmd;              // start condition seen
    logic first;            // first byte after start
    logic sclo;             // clock pin level
    logic sclo_oe;          // clock pin drive
    logic sdao;             // data pin level
    logic sdao_oe;          // data pin drive
    logic push;             // byte to fifo
    logic wt;               // waiting for release
  } sio2_s;
  sio2_s s_q, s_d;

  logic f_ready;
  logic clk_rise, clk_fall, start_cond;
  logic sclk_gen;

  assign clk_rise = s_q.clk_s[1] && !s_q.clk_prev;
  assign clk_fall = !s_q.clk_s[1] && s_q.clk_prev;
  assign start_cond = s_q.clk_s[1] && s_q.dat_prev && !s_q.dat_s[1];

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    s_d = s_q;
    s_d.clk_s = {s_q.clk_s[0], clk_pin_i};
    s_d.dat_s = {s_q.dat_s[0], data_pin_i};
    s_d.clk_prev = s_q.clk_s[1];
    s_d.dat_prev = s_q.dat_s[1];
    s_d.en_prev = iface_enable_flag;
    s_d.push = 1'b0;
    sclk_gen = 1'b0;
    // shift write clears done flag; a set later in this cycle wins
    if (sfr_wr) s_d.irq = 1'b0;
    // start condition tracking
    if (start_cond) begin
      s_d.cmd = 1'b1;
      s_d.first = 1'b1;
      s_d.cnt = '0;
    end
    unique case (s_q.st)
      SIO2_IDLE: begin
        if (sfr_wr && iface_enable_flag &&
            (mode != SIO2_MODE_I2C || !s_q.clk_s[1])) begin
          s_d.sh = sfr_wdata;
          s_d.cnt = '0;
          s_d.st = SIO2_SHIFT;
        end
        if (iface_enable_flag && !s_q.en_prev) s_d.armed = 1'b0;
        if (wake_up_flag && iface_enable_flag && start_cond) begin
          s_d.st = SIO2_SHIFT;
          s_d.sh = SIO2_RX_ONES;
        end
      end
      SIO2_SHIFT: begin
        sclk_gen = !clock_level_control;
        if (clk_rise && sclk_gen) begin
          s_d.sh = {s_q.sh[6:0], s_q.dat_s[1]};
          s_d.cnt = s_q.cnt + 4'h1;
        end
        if (s_q.cnt == SIO2_BITS && clk_fall) begin
          s_d.irq = 1'b1;
          s_d.push = 1'b1;
          if (s_q.first) begin
            s_d.coi = (s_q.sh[7:1] == slave_addr);
            s_d.first = 1'b0;
          end
          s_d.st = (mode == SIO2_MODE_I2C) ? SIO2_WAIT : SIO2_IDLE;
        end
      end
      SIO2_WAIT: begin
        if (sfr_wr) begin
          s_d.sh = sfr_wdata;
          s_d.pend = 1'b1;
        end
        if (wait_release_flag || sfr_wr) begin
          s_d.cnt = '0;
          s_d.st = (sfr_wr || s_q.pend) ? SIO2_SHIFT : SIO2_IDLE;
          s_d.pend = 1'b0;
        end
      end
      default: s_d.st = SIO2_IDLE;
    endcase
    if (release_trigger_flag) s_d.cmd = 1'b0;
    // pin drive
    s_d.sclo_oe = clock_pin_dir_bit;
    if (!iface_enable_flag && mode == SIO2_MODE_I2C) begin
      s_d.sclo = 1'b1;
      s_d.sdao = 1'b0;
      s_d.st = SIO2_IDLE;
    end else begin
      unique case (mode)
        SIO2_MODE_I2C: s_d.sclo = clock_port_bit && clock_level_control;
        SIO2_MODE_2W: s_d.sclo = clock_port_bit;
        default: s_d.sclo = three_wire_clock_port_bit;
      endcase
      s_d.sdao = (busy_enable_flag || wake_up_flag) ? 1'b1 : s_q.sh[7] && data_port_bit;
    end
    // open drain: drive only when pulling low
    s_d.sdao_oe = data_pin_dir_bit && !s_d.sdao;
    s_d.wt = (s_d.st == SIO2_WAIT);
    if (!f_ready) s_d.push = s_q.push;
  end

  ////////////////////////////////////////////////////////////////////////
  // registers
  // hard reset to inputs
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_q <= '{clk_s: 2'h3, dat_s: 2'h3, clk_prev: 1'b1, dat_prev: 1'b1, st: SIO2_IDLE,
               cnt: 4'h0, sh: SIO2_SHIFT_RST, default: 1'b0};
    end else if (!ce_resetn) begin
      s_q.st <= SIO2_IDLE;
      s_q.cnt <= 4'h0;
      s_q.irq <= 1'b0;
      s_q.wt <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  sio2_fifo #(.W(SIO2_FIFO_W), .D(SIO2_FIFO_D)) u_fifo (
    .clock(clock),
    .resetn(resetn),
    .in_data(s_q.sh),
    .in_valid(s_q.push),
    .in_ready(f_ready),
    .out_data(rx_data),
    .out_valid(rx_valid),
    .out_ready(rx_ready)
  );

  assign clk_pin_o = s_q.sclo;
  assign clk_pin_oe = s_q.sclo_oe;
  assign data_pin_o = s_q.sdao;
  assign data_pin_oe = s_q.sdao_oe;
  assign transfer_done_irq_flag = s_q.irq;
  assign clock_level_detect = s_q.clk_s[1];
  assign address_match_flag = s_q.coi;
  assign command_detect_flag = s_q.cmd;
  assign in_wait = s_q.wt;
  assign preset_shift_reg = s_q.sh;

  ////////////////////////////////////////////////////////////////////////
  // checks
  a_forced_clock_high: assert property (@(posedge clock) disable iff (!resetn)
    ce_resetn && iface_enable_flag && mode == SIO2_MODE_I2C && clock_port_bit
    && clock_level_control |=> clk_pin_o) else $error("clock not forced high");
  a_disabled_pins: assert property (@(posedge clock) disable iff (!resetn)
    ce_resetn && !iface_enable_flag && mode == SIO2_MODE_I2C |=> clk_pin_o && !data_pin_o)
    else $error("disabled pins wrong");
  a_done_sets_flag: assert property (@(posedge clock) disable iff (!resetn)
    s_q.push && ce_resetn |-> transfer_done_irq_flag) else $error("done flag missing");
  a_wait_release: assert property (@(posedge clock) disable iff (!resetn)
    in_wait && wait_release_flag && ce_resetn && iface_enable_flag |=> !in_wait)
    else $error("wait not released");
  a_two_wire_latch: assert property (@(posedge clock) disable iff (!resetn)
    ce_resetn && mode == SIO2_MODE_2W |=> clk_pin_o == $past(clock_port_bit))
    else $error("2-wire clock wrong");
  a_three_wire_latch: assert property (@(posedge clock) disable iff (!resetn)
    ce_resetn && mode == SIO2_MODE_3W |=> clk_pin_o == $past(three_wire_clock_port_bit))
    else $error("3-wire clock wrong");
  a_wake_release: assert property (@(posedge clock) disable iff (!resetn)
    ce_resetn && wake_up_flag && !(mode == SIO2_MODE_I2C && !iface_enable_flag)
    |=> !data_pin_oe) else $error("data driven in wake-up");
  a_no_start_idle: assert property (@(posedge clock) disable iff (!resetn)
    s_q.st == SIO2_IDLE && !sfr_wr && !wake_up_flag && ce_resetn |=> s_q.st == SIO2_IDLE)
    else $error("spurious start");
  c_transfer_done: cover property (@(posedge clock) disable iff (!resetn) s_q.push);
  c_wait_entered: cover property (@(posedge clock) disable iff (!resetn) in_wait);
  c_start_seen: cover property (@(posedge clock) disable iff (!resetn) start_cond);
endmodule // sio2_ctrl

//--- design/sio2_fifo.sv
// sio2_fifo: small valid/ready fifo for received bytes
// assumes: one clock, synchronous use on both sides
`timescale 1ns/1ps
module sio2_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(D);
  // storage
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp_q, rp_q;
  logic [AW:0] cnt_q;
  logic push, pop;
  assign in_ready = (cnt_q != (AW+1)'(D));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem[rp_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  // pointers and count
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wp_q <= wp_q + 1'b1;
      if (pop) rp_q <= rp_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  // data write
  always_ff @(posedge clock) begin
    if (push) mem[wp_q] <= in_data;
  end
endmodule // sio2_fifo

//--- design/sio2_pkg.sv
// sio2_pkg: constants and types shared by the serial interface 2 control block
// assumes: 40 MHz system clock, link clock passed through a two-stage synchroniser
package sio2_pkg;
  // serial modes selected by software
  localparam logic [1:0] SIO2_MODE_3W = 2'h0;
  localparam logic [1:0] SIO2_MODE_2W = 2'h1;
  localparam logic [1:0] SIO2_MODE_I2C = 2'h2;
  // bits in one transfer
  localparam logic [3:0] SIO2_BITS = 4'h8;
  // all-ones receive pattern
  localparam logic [7:0] SIO2_RX_ONES = 8'hff;
  // reset values
  localparam logic [7:0] SIO2_SHIFT_RST = 8'h00;
  localparam logic [6:0] SIO2_ADDR_RST = 7'h00;
  // fifo shape
  localparam int SIO2_FIFO_W = 8;
  localparam int SIO2_FIFO_D = 8;
  // engine states, one-hot
  typedef enum logic [2:0] {
    SIO2_IDLE = 3'b001,
    SIO2_SHIFT = 3'b010,
    SIO2_WAIT = 3'b100
  } sio2_state_e;
endpackage : sio2_pkg

//--- testbench/sio2_ctrl_tb_top.sv
// sio2_ctrl_tb_top: self-checking bench for the serial transfer control block
// assumes: link model on the far side, open-drain pull-ups modelled here
`timescale 1ns/1ps
module sio2_ctrl_tb_top;
  import sio2_pkg::*;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic ce_resetn = 1'b1;
  logic [1:0] mode = SIO2_MODE_2W;
  logic en = 1'b1, bsy = 1'b1, clc = 1'b0, cpb = 1'b1, dpb = 1'b1, cdir = 1'b0, ddir = 1'b0;
  logic sfr_wr = 1'b0, rx_ready = 1'b0, wrel = 1'b0, relt = 1'b0;
  logic wt, cmd;
  logic [7:0] sfr_wdata = 8'h00;
  logic clk_o, clk_oe, dat_o, dat_oe, done, cld, rx_valid;
  logic [7:0] rx_data;
  logic [7:0] tbl [8] = '{8'ha5, 8'h01, 8'h80, 8'h3c, 8'hff, 8'h00, 8'h5a, 8'hc3};
  int n_errors = 0;
  int checks = 0;
  // wired-and lines: low if either side pulls low
  wire clk_w = (~clk_oe | clk_o) & i_link.scl_o;
  wire dat_w = (~dat_oe | dat_o) & i_link.sda_o;
  ////////////////////////////////////////////////////////////////
  sio2_link_model i_link();
  sio2_ctrl i_dut (.clock(clock), .resetn(resetn), .ce_resetn(ce_resetn), .mode(mode),
    .iface_enable_flag(en), .busy_enable_flag(bsy), .wake_up_flag(1'b0),
    .clock_level_control(clc), .wait_release_flag(wrel), .release_trigger_flag(relt),
    .clock_port_bit(cpb), .three_wire_clock_port_bit(1'b1), .data_port_bit(dpb),
    .clock_pin_dir_bit(cdir), .data_pin_dir_bit(ddir), .slave_addr(7'h00),
    .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .clk_pin_i(clk_w), .data_pin_i(dat_w),
    .clk_pin_o(clk_o), .clk_pin_oe(clk_oe), .data_pin_o(dat_o), .data_pin_oe(dat_oe),
    .transfer_done_irq_flag(done), .clock_level_detect(cld), .address_match_flag(),
    .command_detect_flag(cmd), .in_wait(wt), .preset_shift_reg(), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_ready(rx_ready));
  ////////////////////////////////////////////////////////////////
  // 40 MHz clock
  initial begin
    forever #12.5 clock = ~clock;
  end
  // compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask
  // one-cycle shift register write
  task automatic wr_sfr(input logic [7:0] d);
    @(negedge clock);
    sfr_wr = 1'b1;
    sfr_wdata = d;
    @(negedge clock);
    sfr_wr = 1'b0;
  endtask
  task automatic close_out();
    $display("errors=%0d checks=%0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // watchdog well past the expected 25 us of traffic
  initial begin
    #200000;
    n_errors++;
    close_out();
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    cyc(12);
    resetn = 1'b1;
    cyc(2);
    chk({dat_oe, clk_oe}, 8'h00);
    // load while disabled, then enable: no transfer
    en = 1'b0;
    wr_sfr(SIO2_RX_ONES);
    en = 1'b1;
    i_link.frame(8'h96);
    cyc(20);
    chk(done, 1'b0);
    // fill the fifo with eight received bytes, sink stalled
    for (int k = 0; k < 8; k++) begin
      // busy enable set before loading ones
      wr_sfr(SIO2_RX_ONES);
      cyc(2);
      chk(done, 1'b0);
      i_link.frame(tbl[k]);
      cyc(20);
      chk(done, 1'b1);
    end
    chk(rx_valid, 1'b1);
    // drain to empty, msb-first bytes in order
    for (int k = 0; k < 8; k++) begin
      chk(rx_data, tbl[k]);
      rx_ready = 1'b1;
      cyc(1);
      rx_ready = 1'b0;
      cyc(1);
    end
    chk(rx_valid, 1'b0);
    // i2c clock idles low, control bit forces it high
    mode = SIO2_MODE_I2C;
    cdir = 1'b1;
    ddir = 1'b1;
    dpb = 1'b0;
    cyc(6);
    chk(cld, 1'b0);
    clc = 1'b1;
    cyc(6);
    chk(cld, 1'b1);
    clc = 1'b0;
    cyc(6);
    chk(clk_w, 1'b0);
    // slave receive: write while clock held low, then release the clock pin
    i_link.scl_o = 1'b0;
    wr_sfr(SIO2_RX_ONES);
    cdir = 1'b0;
    i_link.frame(8'h3c);
    cyc(20);
    chk(done, 1'b1);
    chk(wt, 1'b1);
    chk(rx_data, 8'h3c);
    // no acknowledge: software frees the bus with the release flag
    wrel = 1'b1;
    cyc(1);
    wrel = 1'b0;
    cyc(2);
    chk(wt, 1'b0);
    // start condition from the master sets command detect
    i_link.sda_o = 1'b0;
    cyc(6);
    chk(cmd, 1'b1);
    i_link.sda_o = 1'b1;
    relt = 1'b1;
    cyc(1);
    relt = 1'b0;
    cyc(2);
    chk(cmd, 1'b0);
    cdir = 1'b1;
    cyc(4);
    // disabled in i2c mode: clock high, data low
    en = 1'b0;
    cyc(6);
    chk({clk_w, dat_w}, 8'h02);
    // chip-enable reset keeps pin state
    ce_resetn = 1'b0;
    cyc(3);
    ce_resetn = 1'b1;
    cyc(2);
    chk({clk_w, dat_w}, 8'h02);
    // hard reset returns pins to input
    resetn = 1'b0;
    cyc(2);
    chk({dat_oe, clk_oe}, 8'h00);
    close_out();
  end
endmodule // sio2_ctrl_tb_top

//--- testbench/sio2_link_model.sv
// sio2_link_model: behavioural serial master on the far side of the link
// assumes: open-drain lines with pull-ups, resolved by the bench
`timescale 1ns/1ps
module sio2_link_model;
  logic scl_o = 1'b1; // clock drive, 1 = released
  logic sda_o = 1'b1; // data drive, 1 = released
  ////////////////////////////////////////////////////////////////
  // one byte, msb first, 200 ns per bit; clock stands high between frames
  task automatic frame(input logic [7:0] b);
    #7;
    for (int i = 7; i >= 0; i--) begin
      scl_o = 1'b0;
      #50 sda_o = b[i];
      #50 scl_o = 1'b1;
      #100;
    end
    // closing low phase lets the slave finish the byte
    scl_o = 1'b0;
    #100 sda_o = 1'b1;
    scl_o = 1'b1;
  endtask
endmodule // sio2_link_model
